// ==== hdl/pdmr_defines.vh ====
// Constants for the per-channel datapath mode router.
// Assumes inclusion by bare name from the router module; definitions only.
`ifndef PDMR_DEFINES_VH
`define PDMR_DEFINES_VH

// Line mode codes.
`define PDMR_MODE_LAN 2'h0
`define PDMR_MODE_WAN 2'h1
`define PDMR_MODE_GBE 2'h2

// Host interface codes.
`define PDMR_HOST_XAUI 2'h0
`define PDMR_HOST_RXAUI 2'h1
`define PDMR_HOST_GBE_L0 2'h2
`define PDMR_HOST_GBE_L3 2'h3

// Ingress route selector codes, one-hot.
`define PDMR_RT_PCS10 3'h1
`define PDMR_RT_WIS 3'h2
`define PDMR_RT_PCS1 3'h4

// Configuration state codes, one-hot.
`define PDMR_ST_IDLE 2'h1
`define PDMR_ST_RUN 2'h2

// Reset value of the configuration.
`define PDMR_CFG_RST 4'h0

`endif

// ==== hdl/pdmr_router.v ====
// Per-channel datapath mode router between line-side and host-side stages.
// Assumes all inputs synchronous to clock_i; external coding stages attach to the streams.
`timescale 1ns/10ps
`include "pdmr_defines.vh"

// What this block does
// - LAN ingress line data goes to 10G PCS.
// - WAN ingress line data passes WIS first.
// - Gigabit ingress line data goes to line PCS.
// - Optional timing, security, MAC stages or bypass.
// - 10G host output on four or two lanes.
// - RXAUI uses physical lanes zero and two.
// - Gigabit uses lane zero or three, both ways.
// - 10G egress aligns lanes then 10G PCS.
// - WAN egress framed by WIS before serializing.
// - Gigabit egress host PCS then line PCS.
// - 10G MAC only with security stage enabled.
// - Cross connect line to neighbour host only.
// - Rate buffer bridges line and host domains.
// - Flow-control buffer compensates when MACs enabled.
// - Two gigabit PCS instances, host and line.
// - 10G PCS path has sync and BER monitor.
// - WAN mode applies to both directions together.
module pdmr_router #(
    parameter DW = 64
) (
    // Clock and reset.
    input wire clock_i,
    input wire rstn_i,
    // Configuration, applied when cfg_load_i pulses.
    input wire cfg_load_i,
    input wire [1:0] cfg_mode_i,
    input wire [1:0] cfg_host_i,
    input wire cfg_ts_en_i,
    input wire cfg_sec_en_i,
    input wire cfg_mac_en_i,
    input wire cfg_xconn_en_i,
    // Ingress line data and neighbour line data.
    input wire [DW-1:0] line_rx_data_i,
    input wire line_rx_valid_i,
    input wire [DW-1:0] nbr_line_rx_data_i,
    input wire nbr_line_rx_valid_i,
    // Returns from the optional stages.
    input wire [DW-1:0] opt_ig_data_i,
    input wire [DW-1:0] opt_eg_data_i,
    // Egress host lanes.
    input wire [4*DW-1:0] host_rx_lanes_i,
    input wire [3:0] host_rx_valid_i,
    // Effective configuration seen by all stages.
    output wire [1:0] act_mode_o,
    output wire wan_rx_en_o,
    output wire wan_tx_en_o,
    output wire [2:0] ig_route_o,
    output wire ts_en_o,
    output wire sec_en_o,
    output wire mac_en_o,
    output wire fc_buf_sel_o,
    output wire rate_buf_sel_o,
    output wire host_pcs1_en_o,
    output wire line_pcs1_en_o,
    output wire pcs10_en_o,
    output wire [3:0] host_lane_en_o,
    // Ingress host lanes.
    output reg [4*DW-1:0] host_tx_lanes_o,
    output reg [3:0] host_tx_valid_o,
    // Egress line data.
    output reg [DW-1:0] line_tx_data_o,
    output reg line_tx_valid_o,
    // Stage activity.
    output wire cfg_active_o
);

    // ********************************************************************
    // Configuration register
    // ********************************************************************

    reg [1:0] state_ff; // One-hot configuration state.
    reg [1:0] mode_ff; // Line mode held for both directions.
    reg [1:0] host_ff; // Host interface type.
    reg ts_ff; // Time-stamping stage enable.
    reg sec_ff; // Security stage enable.
    reg mac_ff; // MAC stage enable.
    reg xconn_ff; // Cross connect enable.
    reg [1:0] nxt_host; // Host type made consistent with mode.
    reg nxt_mac; // MAC enable after the speed restriction.

    // Sanitise a requested configuration so that it is always legal.
    always @*
    begin
        nxt_host = cfg_host_i;
        nxt_mac = cfg_mac_en_i;
        if (cfg_mode_i == `PDMR_MODE_GBE)
        begin
            // Gigabit forces a single-lane host choice.
            if (cfg_host_i != `PDMR_HOST_GBE_L3)
            begin
                nxt_host = `PDMR_HOST_GBE_L0;
            end
        end
        else
        begin
            // 10G needs a multi-lane host interface and MAC only with security.
            if (cfg_host_i != `PDMR_HOST_RXAUI)
            begin
                nxt_host = `PDMR_HOST_XAUI;
            end
            nxt_mac = cfg_mac_en_i & cfg_sec_en_i;
        end
    end

    // A single per-channel register set; a reserved mode code falls to LAN.
    always @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            state_ff <= `PDMR_ST_IDLE;
            mode_ff <= `PDMR_MODE_LAN;
            host_ff <= `PDMR_HOST_XAUI;
            {ts_ff, sec_ff, mac_ff, xconn_ff} <= `PDMR_CFG_RST;
        end
        else if (cfg_load_i)
        begin
            // Switching is not hitless; data in flight may be lost.
            state_ff <= `PDMR_ST_RUN;
            mode_ff <= (cfg_mode_i == 2'h3) ? `PDMR_MODE_LAN : cfg_mode_i;
            host_ff <= (cfg_mode_i == 2'h3) ? `PDMR_HOST_XAUI : nxt_host;
            ts_ff <= cfg_ts_en_i;
            sec_ff <= cfg_sec_en_i;
            mac_ff <= (cfg_mode_i == 2'h3) ? (cfg_mac_en_i & cfg_sec_en_i) : nxt_mac;
            xconn_ff <= cfg_xconn_en_i;
        end
    end

    // ********************************************************************
    // Decoded route controls
    // ********************************************************************

    wire is_wan = (mode_ff == `PDMR_MODE_WAN);
    wire is_gbe = (mode_ff == `PDMR_MODE_GBE);
    wire opt_used = ts_ff | sec_ff | mac_ff; // Any optional stage in the path.
    reg [2:0] route_sel; // One-hot ingress route.

    // Ingress first-stage selection follows the line mode.
    always @*
    begin
        case (mode_ff)
            `PDMR_MODE_WAN: route_sel = `PDMR_RT_WIS;
            `PDMR_MODE_GBE: route_sel = `PDMR_RT_PCS1;
            default: route_sel = `PDMR_RT_PCS10;
        endcase
    end

    assign act_mode_o = mode_ff;
    assign ig_route_o = route_sel;
    // One bit drives both directions so they can never disagree.
    assign wan_rx_en_o = is_wan;
    assign wan_tx_en_o = is_wan;
    assign ts_en_o = ts_ff;
    assign sec_en_o = sec_ff;
    assign mac_en_o = mac_ff;
    // The flow buffer replaces the plain rate buffer when MACs run.
    assign fc_buf_sel_o = mac_ff;
    assign rate_buf_sel_o = ~mac_ff;
    // Both gigabit PCS instances run together in gigabit mode.
    assign host_pcs1_en_o = is_gbe;
    assign line_pcs1_en_o = is_gbe;
    // The 10G PCS with sync and BER monitor runs for LAN and WAN.
    assign pcs10_en_o = ~is_gbe;
    assign cfg_active_o = state_ff[1];

    reg [3:0] lane_en; // Physical host lanes in use.

    // Lane usage per host interface type.
    always @*
    begin
        case (host_ff)
            `PDMR_HOST_RXAUI: lane_en = 4'h5;
            `PDMR_HOST_GBE_L0: lane_en = 4'h1;
            `PDMR_HOST_GBE_L3: lane_en = 4'h8;
            default: lane_en = 4'hf;
        endcase
    end
    assign host_lane_en_o = lane_en;

    // ********************************************************************
    // Ingress datapath
    // ********************************************************************

    wire [DW-1:0] ig_src = xconn_ff ? nbr_line_rx_data_i : line_rx_data_i;
    wire ig_vld = xconn_ff ? nbr_line_rx_valid_i : line_rx_valid_i;
    wire [DW-1:0] ig_core = opt_used ? opt_ig_data_i : ig_src;
    wire [DW-1:0] eg_pick = host_ff == `PDMR_HOST_GBE_L3 ? host_rx_lanes_i[4*DW-1:3*DW] : host_rx_lanes_i[DW-1:0];
    wire eg_vld_g = host_ff == `PDMR_HOST_GBE_L3 ? host_rx_valid_i[3] : host_rx_valid_i[0];
    wire eg_vld_r = host_rx_valid_i[0] & host_rx_valid_i[2];
    wire eg_vld_x = &host_rx_valid_i;
    genvar gi;

    // Per-lane ingress drive: data only on enabled lanes, the rest held at zero.
    generate
        for (gi = 0; gi < 4; gi = gi + 1)
        begin : g_lane
            always @(posedge clock_i or negedge rstn_i)
            begin
                if (!rstn_i)
                begin
                    host_tx_lanes_o[gi*DW +: DW] <= {DW{1'b0}};
                    host_tx_valid_o[gi] <= 1'b0;
                end
                else
                begin
                    host_tx_lanes_o[gi*DW +: DW] <= lane_en[gi] ? ig_core : {DW{1'b0}};
                    host_tx_valid_o[gi] <= lane_en[gi] & ig_vld & state_ff[1];
                end
            end
        end
    endgenerate

    // ********************************************************************
    // Egress datapath
    // ********************************************************************

    // Egress never takes neighbour data: the cross connect is one-way.
    always @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            line_tx_data_o <= {DW{1'b0}};
            line_tx_valid_o <= 1'b0;
        end
        else
        begin
            line_tx_data_o <= opt_used ? opt_eg_data_i : eg_pick;
            case (host_ff)
                `PDMR_HOST_RXAUI: line_tx_valid_o <= eg_vld_r & state_ff[1];
                `PDMR_HOST_XAUI: line_tx_valid_o <= eg_vld_x & state_ff[1];
                default: line_tx_valid_o <= eg_vld_g & state_ff[1];
            endcase
        end
    end

endmodule // pdmr_router

// ==== test/pdmr_router_asserts.sv ====
// Port checker for the per-channel mode router.
// Assumes one clock domain; bound into every pdmr_router instance.
`timescale 1ns/10ps
module pdmr_router_asserts (
    input wire clock_i,
    input wire rstn_i,
    input wire cfg_load_i,
    input wire [1:0] cfg_mode_i,
    input wire [3:0] host_rx_valid_i,
    input wire [1:0] act_mode_o,
    input wire wan_rx_en_o,
    input wire wan_tx_en_o,
    input wire [2:0] ig_route_o,
    input wire sec_en_o,
    input wire mac_en_o,
    input wire host_pcs1_en_o,
    input wire line_pcs1_en_o,
    input wire pcs10_en_o,
    input wire [3:0] host_lane_en_o,
    input wire line_tx_valid_o,
    input wire cfg_active_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rstn_i);
    // A load that asks for WAN framing.
    sequence wan_load_s;
        cfg_load_i && cfg_mode_i == 2'h1;
    endsequence
    // A steady XAUI setup with all four host lanes valid.
    sequence xaui_full_s;
        cfg_active_o && !cfg_load_i && host_lane_en_o == 4'hf && host_rx_valid_i == 4'hf;
    endsequence
    wan_both_a: assert property (wan_rx_en_o == wan_tx_en_o) else $error("wan paths differ");
    wan_load_a: assert property (wan_load_s |=> act_mode_o == 2'h1 && wan_tx_en_o)
        else $error("wan load not applied");
    route_dec_a: assert property (ig_route_o == ((act_mode_o == 2'h1) ? 3'h2 : (act_mode_o == 2'h2) ? 3'h4 : 3'h1))
        else $error("ingress route wrong");
    mac_sec_a: assert property (mac_en_o && act_mode_o != 2'h2 |-> sec_en_o) else $error("mac without security");
    gbe_pcs_a: assert property (host_pcs1_en_o == line_pcs1_en_o && pcs10_en_o != host_pcs1_en_o)
        else $error("pcs enables disagree");
    gbe_lane_a: assert property (act_mode_o == 2'h2 |-> host_lane_en_o inside {4'h1, 4'h8})
        else $error("gigabit lane wrong");
    ten_lane_a: assert property (act_mode_o != 2'h2 |-> host_lane_en_o inside {4'hf, 4'h5})
        else $error("10g lanes wrong");
    eg_xaui_a: assert property (xaui_full_s |=> line_tx_valid_o) else $error("egress word lost");
endmodule // pdmr_router_asserts

bind pdmr_router pdmr_router_asserts u_chk (.clock_i, .rstn_i, .cfg_load_i, .cfg_mode_i, .host_rx_valid_i,
    .act_mode_o, .wan_rx_en_o, .wan_tx_en_o, .ig_route_o, .sec_en_o, .mac_en_o, .host_pcs1_en_o,
    .line_pcs1_en_o, .pcs10_en_o, .host_lane_en_o, .line_tx_valid_o, .cfg_active_o);

// ==== test/pdmr_host_model.sv ====
// Host-side partner: drives the egress host lanes.
// Assumes the bench changes the lane mask off the rising edge.
`timescale 1ns/10ps
module pdmr_host_model (
    input wire clock_i,
    input wire [3:0] lane_sel_i,
    input wire [63:0] word_i,
    output reg [255:0] lanes_o = 256'h0,
    output reg [3:0] valid_o = 4'h0
);
    integer n;
    // Idle lanes carry the inverted word, so stale data can never pass as a match.
    always @(negedge clock_i)
    begin
        for (n = 0; n < 4; n = n + 1)
        begin
            lanes_o[n*64 +: 64] <= lane_sel_i[n] ? word_i : ~word_i;
        end
        valid_o <= lane_sel_i;
    end
endmodule // pdmr_host_model

// ==== test/phy_datapath_mode_router_bench.sv ====
// Bench for the mode router: config sweep, ingress and egress lanes.
// Assumes the router, checker and host model compile first.
`timescale 1ns/10ps
module phy_datapath_mode_router_bench;
    reg clock_i = 1'b0;
    reg rstn_i = 1'b0;
    reg cfg_load_i = 1'b0;
    reg [1:0] cfg_mode_i = 2'h0;
    reg [1:0] cfg_host_i = 2'h0;
    reg cfg_ts_en_i = 1'b0;
    reg cfg_sec_en_i = 1'b0;
    reg cfg_mac_en_i = 1'b0;
    reg cfg_xconn_en_i = 1'b0;
    reg [63:0] line_rx_data_i = 64'h1111;
    reg line_rx_valid_i = 1'b0;
    reg [63:0] nbr_line_rx_data_i = 64'h2222;
    reg nbr_line_rx_valid_i = 1'b0;
    reg [63:0] opt_ig_data_i = 64'h3333;
    reg [63:0] opt_eg_data_i = 64'h5555;
    reg [3:0] host_sel = 4'h0;
    wire [255:0] host_rx_lanes_i, host_tx_lanes_o;
    wire [3:0] host_rx_valid_i, host_lane_en_o, host_tx_valid_o;
    wire [1:0] act_mode_o;
    wire [2:0] ig_route_o;
    wire [63:0] line_tx_data_o;
    wire wan_rx_en_o, wan_tx_en_o, ts_en_o, sec_en_o, mac_en_o, fc_buf_sel_o, rate_buf_sel_o;
    wire host_pcs1_en_o, line_pcs1_en_o, pcs10_en_o, line_tx_valid_o, cfg_active_o;
    integer fails = 0;
    integer check_count = 0;
    integer i;
    pdmr_router #(.DW(64)) dut (.clock_i, .rstn_i, .cfg_load_i, .cfg_mode_i, .cfg_host_i, .cfg_ts_en_i,
        .cfg_sec_en_i, .cfg_mac_en_i, .cfg_xconn_en_i, .line_rx_data_i, .line_rx_valid_i, .nbr_line_rx_data_i,
        .nbr_line_rx_valid_i, .opt_ig_data_i, .opt_eg_data_i, .host_rx_lanes_i, .host_rx_valid_i, .act_mode_o,
        .wan_rx_en_o, .wan_tx_en_o, .ig_route_o, .ts_en_o, .sec_en_o, .mac_en_o, .fc_buf_sel_o, .rate_buf_sel_o,
        .host_pcs1_en_o, .line_pcs1_en_o, .pcs10_en_o, .host_lane_en_o, .host_tx_lanes_o, .host_tx_valid_o,
        .line_tx_data_o, .line_tx_valid_o, .cfg_active_o);
    pdmr_host_model host (.clock_i, .lane_sel_i(host_sel), .word_i(64'h4444), .lanes_o(host_rx_lanes_i),
        .valid_o(host_rx_valid_i));
    // Clock of 50 ns.
    initial
    begin
        forever #25 clock_i = ~clock_i;
    end
    task chk(input [255:0] exp, input [255:0] got, input string what);
    begin
        check_count = check_count + 1;
        if (got !== exp)
        begin
            fails = fails + 1;
            $display("MISMATCH %s exp %h got %h", what, exp, got);
        end
    end
    endtask
    // The en argument packs {xconn, mac, sec, ts}; waits until controls settle.
    task load(input [1:0] m, input [1:0] h, input [3:0] en);
    begin
        {cfg_xconn_en_i, cfg_mac_en_i, cfg_sec_en_i, cfg_ts_en_i} = en;
        cfg_mode_i = m;
        cfg_host_i = h;
        cfg_load_i = 1'b1;
        @(negedge clock_i);
        cfg_load_i = 1'b0;
        @(negedge clock_i);
    end
    endtask
    // Sweeps every mode and host code, MAC always asked for, security off for the first 16 loads and on for the last 16.
    task t_modes;
        reg [1:0] me;
        reg [3:0] ln;
        reg mc;
    begin
        for (i = 0; i < 32; i = i + 1)
        begin
            me = (i[3:2] == 2'h3) ? 2'h0 : i[3:2];
            // A reserved mode code falls back to LAN on all four XAUI lanes.
            ln = (me == 2'h2) ? ((i[1:0] == 2'h3) ? 4'h8 : 4'h1) : ((i[1:0] == 2'h1 && i[3:2] != 2'h3) ? 4'h5 : 4'hf);
            mc = i[4] | me == 2'h2;
            load(i[3:2], i[1:0], {2'b01, i[4], i[0]});
            chk({act_mode_o, ig_route_o, host_lane_en_o}, {me, (me == 2'h0) ? 3'h1 : {me, 1'b0}, ln}, "route");
            chk({wan_rx_en_o, wan_tx_en_o, line_pcs1_en_o, pcs10_en_o}, {{2{me == 2'h1}}, me == 2'h2, me != 2'h2}, "paths");
            chk({ts_en_o, sec_en_o, mac_en_o, fc_buf_sel_o, rate_buf_sel_o}, {i[0], i[4], mc, mc, ~mc}, "stages");
        end
        $display("test modes done");
    end
    endtask
    // Ingress word on the host lanes; sv packs {neighbour, own} line valids, le the lanes carrying data.
    task ing(input [1:0] m, input [1:0] h, input [3:0] en, input [1:0] sv, input [3:0] ev, input [3:0] le);
        reg [63:0] w;
    begin
        load(m, h, en);
        {nbr_line_rx_valid_i, line_rx_valid_i} = sv;
        w = (en[2:0] != 3'h0) ? opt_ig_data_i : (en[3] ? nbr_line_rx_data_i : line_rx_data_i);
        repeat (2) @(negedge clock_i);
        chk(ev, host_tx_valid_o, "ig valid");
        chk({{64{le[3]}} & w, {64{le[2]}} & w, {64{le[1]}} & w, {64{le[0]}} & w}, host_tx_lanes_o, "ig lanes");
        {nbr_line_rx_valid_i, line_rx_valid_i} = 2'b00;
        $display("test ingress done");
    end
    endtask
    // Egress word from the host model on the lanes in sel.
    task egr(input [1:0] m, input [1:0] h, input [3:0] en, input [3:0] sel, input ev);
    begin
        load(m, h, en);
        host_sel = sel;
        repeat (3) @(negedge clock_i);
        chk(ev, line_tx_valid_o, "eg valid");
        if (ev)
            chk((en[2:0] != 3'h0) ? opt_eg_data_i : 64'h4444, line_tx_data_o, "eg data");
        host_sel = 4'h0;
        $display("test egress done");
    end
    endtask
    task test_done;
    begin
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    end
    endtask
    // Main sequence: reset state, sweep, then data in both directions.
    initial
    begin
        repeat (5) @(negedge clock_i);
        chk({act_mode_o, host_lane_en_o, ig_route_o, cfg_active_o, host_tx_valid_o, line_tx_valid_o}, 15'h1e40, "reset");
        rstn_i = 1'b1;
        t_modes;
        ing(2'h0, 2'h0, 4'h0, 2'b01, 4'hf, 4'hf);
        ing(2'h1, 2'h1, 4'h0, 2'b01, 4'h5, 4'h5);
        ing(2'h2, 2'h3, 4'h0, 2'b01, 4'h8, 4'h8);
        ing(2'h0, 2'h1, 4'h8, 2'b10, 4'h5, 4'h5);
        ing(2'h2, 2'h2, 4'h0, 2'b10, 4'h0, 4'h1);
        ing(2'h0, 2'h0, 4'h1, 2'b01, 4'hf, 4'hf);
        egr(2'h0, 2'h0, 4'h0, 4'hf, 1'b1);
        egr(2'h0, 2'h0, 4'h0, 4'h7, 1'b0);
        egr(2'h1, 2'h1, 4'h0, 4'h5, 1'b1);
        egr(2'h2, 2'h3, 4'h0, 4'h8, 1'b1);
        egr(2'h2, 2'h3, 4'h0, 4'h1, 1'b0);
        egr(2'h2, 2'h2, 4'h4, 4'h1, 1'b1);
        test_done;
    end
    // Watchdog: the run needs about 125 cycles, so 2000 means a hang.
    initial
    begin
        #100000;
        fails = fails + 1;
        test_done;
    end
endmodule // phy_datapath_mode_router_bench
